// ---- hdl/perl_defs.vh ----
// constants for the programming executive serial response link
`ifndef PERL_DEFS_VH
`define PERL_DEFS_VH
// ----------------------------------------------------------------
// word framing and timing
// ----------------------------------------------------------------
`define PERL_WORD_BITS 16
`define PERL_CLK_MHZ 100
`define PERL_READY_US 15
`define PERL_READY_CYC (`PERL_READY_US * `PERL_CLK_MHZ)
// ----------------------------------------------------------------
// response opcodes
// ----------------------------------------------------------------
`define PERL_RSP_PASS 4'h1
`define PERL_RSP_FAIL 4'h2
`define PERL_RSP_UNKNOWN 4'h3
// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define PERL_CMD_READ_DATA 4'h1
`define PERL_CMD_READ_PROG 4'h2
`define PERL_CMD_PROG_DATA 4'h5
`define PERL_CMD_PROG_CODE 4'h6
`define PERL_CMD_PROG_CONFIG 4'h7
`define PERL_CMD_QUERY_BLANK 4'ha
`define PERL_CMD_QUERY_VERSION 4'hb
// ----------------------------------------------------------------
// query and error bytes, header word count
// ----------------------------------------------------------------
`define PERL_QE_NO_ERROR 8'h00
`define PERL_QE_VERIFY_FAIL 8'h01
`define PERL_QE_OTHER_ERROR 8'h02
`define PERL_QE_NOT_BLANK 8'h0f
`define PERL_QE_BLANK 8'hf0
`define PERL_HDR_WORDS 16'h0002
`endif

// ---- hdl/perl_buffer.v ----
// two-entry valid/ready buffer for response words
`timescale 1ns/1ns
module perl_buffer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:1];
  reg rd_ptr;
  reg wr_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'd0;
      mem[0] <= {WIDTH{1'b0}};
      mem[1] <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'd1;
      else if (pop && !push)
        count <= count - 2'd1;
    end
  end
endmodule // perl_buffer

// ---- hdl/perl_link.v ----
// programming executive serial command and response link
`timescale 1ns/1ns
`include "perl_defs.vh"

// How it works
// R1: programmer sends a command first and waits for its response.
// R2: exactly one response per command, only after processing ends.
// R3: serial clock is an input only, never driven here.
// R4: drive data after falling clock edge, sample on rising edge.
// R5: all words are 16 bits, most significant bit first.
// R6: programmer releases data pin after the last command word.
// R7: data pin held high while the command is processed.
// R8: data pin driven low 15 us to flag the response ready.
// R9: opcode pass 0x1, fail 0x2 with reason in query/error byte.
// R10: unknown command opcode answered with opcode 0x3.
// R11: header word: opcode, echoed command, query/error byte; then length.
// R12: echoed field holds the opcode of the command answered.
// R13: query commands always pass with result in query/error byte.
// R14: blank query gives 0x0f not blank, 0xf0 blank.
// R15: version query opcode 0xb length 2, version byte in header.
// R16: non-query error byte: 0 none, 1 verify failed, 2 other.
// R17: length counts words with header; others are 2 words.
// R18: data read response is N plus 2 words.
// R19: program read response 3*N/2+2 words, odd N rounded up.
// R20: response words clocked out by programmer, then pin released.
module perl_link #(
  parameter READY_CYC = `PERL_READY_CYC,
  parameter [7:0] VERSION = 8'h10 // arbitrary value
) (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // serial pins
  input wire prog_serial_clock_pin,
  input wire prog_serial_data_pin_in,
  output reg prog_serial_data_pin_out,
  output reg prog_serial_data_pin_oe,
  // command words to the executive core
  output reg cmd_valid,
  output reg [15:0] cmd_word,
  output reg cmd_first,
  // processing outcome from the core
  input wire done_valid,
  input wire done_fail,
  input wire done_verify,
  input wire done_blank,
  // response data words from the core
  input wire data_valid,
  output wire data_ready,
  input wire [15:0] data_word
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [5:0] ST_CMD = 6'b000001;
  localparam [5:0] ST_BUSY = 6'b000010;
  localparam [5:0] ST_READY = 6'b000100;
  localparam [5:0] ST_HDR = 6'b001000;
  localparam [5:0] ST_DATA = 6'b010000;
  localparam [5:0] ST_END = 6'b100000;

  reg [5:0] state;
  reg [2:0] clk_sync;
  reg [1:0] dat_sync;
  reg [3:0] bit_cnt;
  reg [15:0] shift_in;
  reg [15:0] shift_out;
  reg [15:0] words_left;
  reg [15:0] cmd_len;
  reg [15:0] hdr0;
  reg [15:0] hdr1;
  reg [3:0] cmd_op;
  reg [19:0] pulse_cnt;
  reg hdr_sel;
  reg loaded;
  wire rise;
  wire fall;
  wire buf_valid;
  wire [15:0] buf_word;
  reg buf_take;
  wire [15:0] rx_word;
  wire [11:0] rx_len;
  wire pulse_end;

  // ----------------------------------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_sync <= 3'b000;
      dat_sync <= 2'b00;
    end
    else
    begin
      clk_sync <= {clk_sync[1:0], prog_serial_clock_pin}; // R3
      dat_sync <= {dat_sync[0], prog_serial_data_pin_in};
    end
  end

  // edges judged on the second and third stages only
  assign rise = clk_sync[1] && !clk_sync[2];
  assign fall = !clk_sync[1] && clk_sync[2];

  // ----------------------------------------------------------------
  // received word, with the bit of this rising edge already in
  // ----------------------------------------------------------------
  assign rx_word = {shift_in[14:0], dat_sync[1]};
  assign rx_len = rx_word[11:0];

  // ----------------------------------------------------------------
  // response length and header
  // ----------------------------------------------------------------
  function [15:0] resp_len;
    input [3:0] op;
    input [15:0] n;
    reg [15:0] m;
    begin
      m = n + {15'd0, n[0]};
      if (op == `PERL_CMD_READ_DATA)
        resp_len = n + `PERL_HDR_WORDS; // R18
      else if (op == `PERL_CMD_READ_PROG)
        resp_len = m + {1'b0, m[15:1]} + `PERL_HDR_WORDS; // R19
      else
        resp_len = `PERL_HDR_WORDS; // R17
    end
  endfunction

  function known_op;
    input [3:0] op;
    begin
      case (op)
        `PERL_CMD_READ_DATA, `PERL_CMD_READ_PROG,
        `PERL_CMD_PROG_DATA, `PERL_CMD_PROG_CODE,
        `PERL_CMD_PROG_CONFIG, `PERL_CMD_QUERY_BLANK,
        `PERL_CMD_QUERY_VERSION: known_op = 1'b1;
        default: known_op = 1'b0;
      endcase
    end
  endfunction

  // the two read commands carry their word count in the last word
  function reads_memory;
    input [3:0] op;
    begin
      reads_memory = (op == `PERL_CMD_READ_DATA) ||
        (op == `PERL_CMD_READ_PROG);
    end
  endfunction

  // first header word; unknown opcodes never look at the outcome bits
  function [15:0] hdr_word;
    input [3:0] op;
    input fail;
    input verify;
    input blank;
    begin
      if (!known_op(op))
        hdr_word = {`PERL_RSP_UNKNOWN, op, `PERL_QE_NO_ERROR}; // R10
      else if (op == `PERL_CMD_QUERY_BLANK)
        hdr_word = {`PERL_RSP_PASS, op, // R13 R14
          blank ? `PERL_QE_BLANK : `PERL_QE_NOT_BLANK};
      else if (op == `PERL_CMD_QUERY_VERSION)
        hdr_word = {`PERL_RSP_PASS, op, VERSION}; // R15
      else if (fail)
        hdr_word = {`PERL_RSP_FAIL, op, // R9 R16
          verify ? `PERL_QE_VERIFY_FAIL : `PERL_QE_OTHER_ERROR};
      else
        hdr_word = {`PERL_RSP_PASS, op, `PERL_QE_NO_ERROR}; // R11 R12
    end
  endfunction

  // ----------------------------------------------------------------
  // response data buffer, stalls the core when the programmer lags
  // ----------------------------------------------------------------
  perl_buffer #(
    .WIDTH(16)
  ) u_buf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(data_valid),
    .in_ready(data_ready),
    .in_data(data_word),
    .out_valid(buf_valid),
    .out_ready(buf_take),
    .out_data(buf_word)
  );

  always @*
  begin
    buf_take = (state == ST_DATA) && !loaded && buf_valid;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  // last cycle of the ready pulse
  assign pulse_end = (pulse_cnt == READY_CYC - 1);

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_CMD;
      bit_cnt <= 4'd0;
      shift_in <= 16'h0000;
      shift_out <= 16'h0000;
      words_left <= 16'h0000;
      cmd_len <= 16'h0000;
      hdr0 <= 16'h0000;
      hdr1 <= 16'h0000;
      cmd_op <= 4'h0;
      pulse_cnt <= 20'd0;
      hdr_sel <= 1'b0;
      loaded <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_word <= 16'h0000;
      cmd_first <= 1'b0;
      prog_serial_data_pin_out <= 1'b0;
      prog_serial_data_pin_oe <= 1'b0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      case (state)
        ST_CMD:
        begin
          // the pin belongs to the programmer while words come in
          prog_serial_data_pin_oe <= 1'b0;
          if (rise)
          begin
            shift_in <= {shift_in[14:0], dat_sync[1]}; // R4 R5
            bit_cnt <= bit_cnt + 4'd1;
            if (bit_cnt == 4'd15)
            begin
              cmd_valid <= 1'b1;
              cmd_word <= rx_word;
              cmd_first <= (words_left == 16'h0000);
              if (words_left == 16'h0000)
              begin
                cmd_op <= rx_word[15:12];
                // length field counts command words
                if (rx_len <= 12'd1)
                begin
                  // the programmer may still drive the pin for up to one more cycle
                  state <= ST_BUSY; // R6
                  prog_serial_data_pin_oe <= 1'b1;
                  prog_serial_data_pin_out <= 1'b1;
                  cmd_len <= 16'h0000;
                end
                else
                  words_left <= {4'd0, rx_len} - 16'd1;
              end
              else
              begin
                if (words_left == 16'd1 && reads_memory(cmd_op))
                  cmd_len <= rx_word; // R18 R19
                words_left <= words_left - 16'd1;
                if (words_left == 16'd1)
                begin
                  state <= ST_BUSY; // R1 R6
                  prog_serial_data_pin_oe <= 1'b1;
                  prog_serial_data_pin_out <= 1'b1;
                end
              end
            end
          end
        end
        ST_BUSY:
        begin
          prog_serial_data_pin_out <= 1'b1; // R7
          // unknown commands never wait on the core
          if (!known_op(cmd_op) || done_valid)
          begin
            state <= ST_READY; // R2
            pulse_cnt <= 20'd0;
            prog_serial_data_pin_out <= 1'b0; // R8
            hdr1 <= resp_len(cmd_op, cmd_len); // R17
            words_left <= resp_len(cmd_op, cmd_len);
            hdr0 <= hdr_word(cmd_op, done_fail, done_verify, done_blank);
          end
        end
        ST_READY:
        begin
          // line stays low; the header waits for the next falling edge
          pulse_cnt <= pulse_cnt + 20'd1;
          if (pulse_end)
          begin
            state <= ST_HDR;
            shift_out <= hdr0;
            hdr_sel <= 1'b0;
            bit_cnt <= 4'd0;
          end
        end
        ST_HDR, ST_DATA:
        begin
          // the buffer refills shift_out only between words
          if (buf_take)
          begin
            shift_out <= buf_word;
            loaded <= 1'b1;
          end
          if (fall && (state == ST_HDR || loaded))
          begin
            prog_serial_data_pin_out <= shift_out[15]; // R4 R5 R20
            shift_out <= {shift_out[14:0], 1'b0};
            bit_cnt <= bit_cnt + 4'd1;
            if (bit_cnt == 4'd15)
            begin
              words_left <= words_left - 16'd1;
              loaded <= 1'b0;
              if (words_left == 16'd1)
                state <= ST_END;
              else if (state == ST_HDR && !hdr_sel)
              begin
                hdr_sel <= 1'b1;
                // length loads whole, its top bit leaves on the next fall
                shift_out <= hdr1;
              end
              else
                state <= ST_DATA;
            end
            else if (bit_cnt == 4'd0 && state == ST_HDR && hdr_sel)
              prog_serial_data_pin_out <= hdr1[15];
          end
        end
        ST_END:
        begin
          // hold the last bit until the programmer samples it
          if (rise)
          begin
            state <= ST_CMD;
            prog_serial_data_pin_oe <= 1'b0; // R20
            words_left <= 16'h0000;
            bit_cnt <= 4'd0;
          end
        end
        default:
          state <= ST_CMD;
      endcase
    end
  end
endmodule // perl_link

// ---- dv/perl_props.sv ----
// assertion checker for the serial response link
`timescale 1ns/1ns
module perl_props #(
  parameter READY_CYC = 1500
) (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // serial pins
  input wire prog_serial_clock_pin,
  input wire prog_serial_data_pin_out,
  input wire prog_serial_data_pin_oe,
  // core side
  input wire cmd_valid,
  input wire [15:0] cmd_word,
  input wire cmd_first,
  input wire done_valid
);
  // ----------------------------------------------------------------
  // phase tracking: idle, busy, ready pulse, data
  // ----------------------------------------------------------------
  reg [1:0] ph;
  reg [15:0] lowc;
  reg got_done;
  reg [3:0] op;
  wire sck = prog_serial_clock_pin;
  wire dout = prog_serial_data_pin_out;
  wire doe = prog_serial_data_pin_oe;
  // a one-word command takes the pin in the cycle its opcode shows up
  wire [3:0] op_now = (cmd_valid && cmd_first) ? cmd_word[15:12] : op;
  wire known = op_now inside {4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb};
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ph <= 2'd0;
      lowc <= 16'h0;
      got_done <= 1'b0;
      op <= 4'h0;
    end
    else
    begin
      if (cmd_valid && cmd_first)
        op <= cmd_word[15:12];
      if (done_valid)
        got_done <= 1'b1;
      if (!doe)
      begin
        ph <= 2'd0;
        got_done <= 1'b0;
      end
      else if (ph == 2'd0)
        ph <= 2'd1;
      else if (ph == 2'd1 && !dout)
      begin
        ph <= 2'd2;
        lowc <= 16'h1;
      end
      else if (ph == 2'd2 && dout)
        ph <= 2'd3;
      else if (ph == 2'd2)
        lowc <= lowc + 16'h1;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  a_busy_first: assert property ($rose(doe) |-> dout)
    else $error("data pin not high when taken over");
  a_busy_early: assert property (ph == 2'd1 && !dout |-> got_done || !known)
    else $error("busy ended before processing finished");
  a_done_ready: assert property (ph == 2'd1 && done_valid |-> ##[1:4] !dout)
    else $error("no ready pulse after processing");
  a_ready_len: assert property (ph == 2'd2 && dout |-> lowc >= READY_CYC)
    else $error("ready pulse too short");
  a_unknown_fast: assert property ($rose(doe) && !known |=> ##[0:3] !dout)
    else $error("unknown command kept busy");
  a_drive_on_fall: assert property (doe && $past(doe) && dout != $past(dout)
    && ph[1] |-> !sck && !$past(sck))
    else $error("data changed away from falling clock");
  a_release_rise: assert property ($fell(doe) |-> sck && $past(sck))
    else $error("pin released away from rising clock");
  a_word_space: assert property (cmd_valid |=> !cmd_valid [*8])
    else $error("command words too close");
endmodule // perl_props

bind perl_link perl_props #(.READY_CYC(READY_CYC)) i_props (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .prog_serial_clock_pin(prog_serial_clock_pin),
  .prog_serial_data_pin_out(prog_serial_data_pin_out),
  .prog_serial_data_pin_oe(prog_serial_data_pin_oe),
  .cmd_valid(cmd_valid),
  .cmd_word(cmd_word),
  .cmd_first(cmd_first),
  .done_valid(done_valid)
);

// ---- dv/perl_prog_model.sv ----
// programmer model: serial clock master on the data pin
`timescale 1ns/1ns
module perl_prog_model (
  // serial pins
  output reg sclk,
  output reg sd,
  output reg sd_oe,
  input wire pin
);
  initial
  begin
    sclk = 1'b0; // clock stands low between frames
    sd = 1'b0;
    sd_oe = 1'b0;
  end
  task put_word(input [15:0] w, input last);
    integer i;
    begin
      sd_oe = 1'b1;
      for (i = 15; i >= 0; i = i - 1)
      begin
        sd = w[i]; // msb first, set while clock low
        #40 sclk = 1'b1;
        // let go late enough that the latched bit is safe
        #30 sd_oe = sd_oe && !(last && i == 0);
        #10 sclk = 1'b0;
      end
    end
  endtask
  task lead;
    begin
      sclk = 1'b1;
      #40 sclk = 1'b0; // this fall starts the response
      #40;
    end
  endtask
  task get_word(output [15:0] w);
    integer i;
    begin
      for (i = 15; i >= 0; i = i - 1)
      begin
        sclk = 1'b1;
        w[i] = pin; // taken at the rising edge
        #40 sclk = 1'b0;
        #40;
      end
    end
  endtask
endmodule // perl_prog_model

// ---- dv/testbench.sv ----
// self-checking bench for the serial response link
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    total_checks = total_checks + 1; \
    if ((got) !== (ex)) \
    begin \
      errors = errors + 1; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end
module testbench;
  localparam RDY = 20;
  localparam [7:0] VER = 8'h5c; // arbitrary value
  reg clk_sys, rstn, done_valid, done_fail, done_verify, done_blank;
  reg data_valid, flt;
  reg [15:0] data_word, last_cmd, w, e;
  reg [15:0] dq[$];
  reg [15:0] eq[$];
  wire sclk, sd, sd_oe, d_out, d_oe, cmd_valid, cmd_first, data_ready;
  wire [15:0] cmd_word;
  // undriven pin toggles so a stale level is never mistaken for data
  wire pin = d_oe ? d_out : (sd_oe ? sd : flt);
  integer errors, total_checks, cyc, seed, k, r;
  perl_link #(.READY_CYC(RDY), .VERSION(VER)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .prog_serial_clock_pin(sclk),
    .prog_serial_data_pin_in(pin), .prog_serial_data_pin_out(d_out),
    .prog_serial_data_pin_oe(d_oe), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .cmd_first(cmd_first), .done_valid(done_valid),
    .done_fail(done_fail), .done_verify(done_verify),
    .done_blank(done_blank), .data_valid(data_valid),
    .data_ready(data_ready), .data_word(data_word));
  perl_prog_model i_prog (.sclk(sclk), .sd(sd), .sd_oe(sd_oe), .pin(pin));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    flt <= ~flt;
    if (cmd_valid === 1'b1)
      last_cmd <= cmd_word;
    if (data_valid === 1'b1 && data_ready === 1'b1)
      void'(dq.pop_front());
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      errors = errors + 1;
      give_verdict;
    end
    #1;
    data_valid = dq.size() > 0;
    data_word = dq.size() > 0 ? dq[0] : 16'h0;
  end
  function [15:0] exp_len(input [3:0] op, input [15:0] n);
    exp_len = op == 4'h1 ? n + 16'h2 :
      op == 4'h2 ? 16'h3 * ((n + 16'h1) >> 1) + 16'h2 : 16'h2;
  endfunction
  function [15:0] exp_hdr(input [3:0] op, input fl, vf, bl);
    if (!(op inside {4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb}))
      exp_hdr = {4'h3, op, 8'h00};
    else if (op == 4'ha)
      exp_hdr = {4'h1, op, bl ? 8'hf0 : 8'h0f};
    else if (op == 4'hb)
      exp_hdr = {4'h1, op, VER};
    else if (fl)
      exp_hdr = {4'h2, op, vf ? 8'h01 : 8'h02};
    else
      exp_hdr = {4'h1, op, 8'h00};
  endfunction
  task run(input [3:0] op, input [15:0] n, input fl, vf, bl);
    reg rd;
    integer i, len, t;
    begin
      rd = op == 4'h1 || op == 4'h2;
      fl = fl && !rd;
      len = exp_len(op, n);
      @(posedge clk_sys);
      #1 i_prog.put_word({op, rd ? 12'h002 : 12'h001}, !rd);
      if (rd)
        i_prog.put_word(n, 1'b1);
      repeat (6) @(posedge clk_sys);
      `CHK("cmd_word", rd ? n : {op, 12'h001}, last_cmd)
      if (exp_hdr(op, 0, 0, 0) >> 12 != 16'h3)
      begin
        `CHK("busy", 1'b1, pin)
        for (i = 2; i < len; i = i + 1)
        begin
          w = $random(seed);
          dq.push_back(w);
          eq.push_back(w);
        end
        #1 done_valid = 1'b1;
        {done_fail, done_verify, done_blank} = {fl, vf, bl};
        @(posedge clk_sys);
        #1 done_valid = 1'b0;
      end
      t = 0;
      while (pin !== 1'b0 && t < 200)
      begin
        @(posedge clk_sys);
        t = t + 1;
      end
      `CHK("ready", 1'b0, pin)
      repeat (RDY + 4) @(posedge clk_sys);
      #1 i_prog.lead;
      i_prog.get_word(w);
      `CHK("header", exp_hdr(op, fl, vf, bl), w)
      i_prog.get_word(w);
      `CHK("length", len[15:0], w)
      for (i = 2; i < len; i = i + 1)
      begin
        i_prog.get_word(w);
        e = eq.pop_front();
        `CHK("data", e, w)
      end
      repeat (8) @(posedge clk_sys);
      `CHK("released", 1'b0, d_oe)
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial
  begin
    {rstn, done_valid, done_fail, done_verify, done_blank} = 5'h00;
    {data_valid, flt, data_word, last_cmd} = 34'h0;
    {errors, total_checks, cyc} = 0;
    seed = 32'h9abd;
    repeat (12) @(posedge clk_sys);
    `CHK("oe_reset", 1'b0, d_oe)
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk_sys);
    // every command code, odd and even counts, each error kind
    run(4'h1, 16'h1, 0, 0, 0);
    run(4'h1, 16'h6, 0, 0, 0);
    run(4'h2, 16'h1, 0, 0, 0);
    run(4'h2, 16'h4, 0, 0, 0);
    run(4'h5, 16'h0, 1, 1, 0);
    run(4'h6, 16'h0, 1, 0, 0);
    run(4'h7, 16'h0, 0, 0, 0);
    run(4'ha, 16'h0, 1, 0, 1);
    run(4'ha, 16'h0, 0, 0, 0);
    run(4'hb, 16'h0, 1, 0, 0);
    run(4'h0, 16'h0, 0, 0, 0);
    run(4'hf, 16'h0, 0, 0, 0);
    for (k = 0; k < 10; k = k + 1)
    begin
      r = $random(seed);
      run(r[3:0], {13'h0, r[6:4]} + 16'h1, r[7], r[8], r[9]);
    end
    give_verdict;
  end
endmodule // testbench
